// file: verilog/gpd_defines.svh
// Constant offsets, fields, reset values and timing counts for the bus interface.
`ifndef GPD_DEFINES_SVH
`define GPD_DEFINES_SVH
`define GPD_ADDR_RESET 5'h10
`define GPD_ADDR_MAX 5'h1e
`define GPD_CMD_GTL 8'h01
`define GPD_CMD_SDC 8'h04
`define GPD_CMD_GET 8'h08
`define GPD_CMD_LLO 8'h11
`define GPD_CMD_DCL 8'h14
`define GPD_CMD_SPE 8'h18
`define GPD_CMD_SPD 8'h19
`define GPD_CMD_UNL 8'h3f
`define GPD_CMD_UNT 8'h5f
`define GPD_GRP_LISTEN 3'h1
`define GPD_GRP_TALK 3'h2
`define GPD_CLK_MHZ 40
`define GPD_IFC_MIN_US 100
`define GPD_IFC_CYCLES ((`GPD_IFC_MIN_US) * (`GPD_CLK_MHZ))
`define GPD_IFC_CNT_W 13
`endif

// file: verilog/gpd_pkg.sv
// Types shared by the bus interface block.
package gpd_pkg;
   // Command byte as seen with attention asserted.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } gpd_cmd_t;
   // Indicator outputs of the interface.
   typedef struct packed {
      logic remote;
      logic talk;
      logic listen;
      logic lockout;
   } gpd_ind_t;
   typedef enum logic [1:0] {
      GPD_LOCAL = 2'b00,
      GPD_REMOTE = 2'b01,
      GPD_RWLS = 2'b10
   } gpd_rl_t;
endpackage

// file: verilog/gpd_device.sv
// Device-side instrument bus interface: addressing, remote/local and bus commands.
// What this block does
// - Primary address starts at 16 after reset until changed.
// - Address settings 0 to 30 accepted, others rejected.
// - Remote entered only when addressed to listen with remote enable true.
// - Talker addressing works in both remote and local.
// - In remote, front-panel keys ignored except local key.
// - Local key returns to local unless lockout is in effect.
// - Interface clear forces local, talker idle and listener idle.
// - Interface clear turns off talk and listen indicators.
// - Interface clear leaves settings, data and event registers alone.
// - After local lockout the local key no longer works.
// - Addressed go-to-local cancels remote and restores front panel.
// - Device clear pulses dev_clear only; interface state is left as it was.
// - Selective device clear acts only when addressed to listen.
// - Serial poll presents status byte while polled.
// - Group trigger fires only when bus trigger is control source.
// - Device clear empties buffers, cancels deferred commands, keeps settings.
// - Talker leaves active on untalk, another talk address, own listen address or interface clear.
`include "gpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gpd_device
   import gpd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus lines, raw from the pins
   input wire logic ren_pin,
   input wire logic ifc_pin,
   input wire logic atn_pin,
   input wire logic dav_pin,
   input wire logic [7:0] dio_pin,
   // Address setting from the front panel
   input wire logic [4:0] addr_set,
   input wire logic addr_set_stb,
   output logic addr_reject,
   // Front panel
   input wire logic local_key,
   input wire logic [7:0] panel_keys,
   output logic [7:0] panel_keys_ok,
   // Instrument side
   input wire logic [7:0] status_byte,
   input wire logic trig_src_bus,
   output logic trig_evt,
   output logic dev_clear,
   output logic [4:0] prim_addr,
   // Bus answer and indicators
   output logic [7:0] dio_out,
   output logic dio_oe,
   output logic remote_indicator,
   output logic talk_indicator,
   output logic listen_indicator,
   output logic lockout
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [11:0] sync1;
   logic [11:0] sync2;
   logic [11:0] next_sync1;
   // Pins are asynchronous to clk; only sync2 is read by logic.
   always_comb begin
      next_sync1 = {ren_pin, ifc_pin, atn_pin, dav_pin, dio_pin};
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1 <= 12'h000;
         sync2 <= 12'h000;
      end else begin
         sync1 <= next_sync1;
         sync2 <= sync1;
      end
   end
   logic ren_s, ifc_s, atn_s, dav_s;
   logic [7:0] dio_s;
   assign {ren_s, ifc_s, atn_s, dav_s, dio_s} = sync2;

   // ----------------------------------------
   // Interface clear qualifier and command strobe
   // ----------------------------------------
   logic [`GPD_IFC_CNT_W-1:0] ifc_cnt, next_ifc_cnt;
   logic ifc_done, next_ifc_done;
   logic dav_d, next_dav_d;
   logic ifc_evt;
   gpd_cmd_t cmd;
   // qualify clear length; a glitch shorter than the minimum is ignored.
   always_comb begin
      next_ifc_cnt = ifc_cnt;
      next_ifc_done = ifc_done;
      ifc_evt = 1'b0;
      if (!ifc_s) begin
         next_ifc_cnt = '0;
         next_ifc_done = 1'b0;
      end else if (ifc_cnt < `GPD_IFC_CNT_W'(`GPD_IFC_CYCLES - 1)) begin
         next_ifc_cnt = ifc_cnt + 1'b1;
      end else if (!ifc_done) begin
         next_ifc_done = 1'b1;
         ifc_evt = 1'b1;
      end
      // Edge detect on the synced strobe; dav_d resets low like the idle line, so reset makes no false byte.
      next_dav_d = dav_s;
      cmd.valid = dav_s && !dav_d;
      cmd.data = dio_s;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ifc_cnt <= '0;
         ifc_done <= 1'b0;
         dav_d <= 1'b0;
      end else begin
         ifc_cnt <= next_ifc_cnt;
         ifc_done <= next_ifc_done;
         dav_d <= next_dav_d;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic my_listen, my_talk, cmd_atn;
   // compare five-bit field of address commands.
   assign cmd_atn = cmd.valid && atn_s && !ifc_done;
   assign my_listen = cmd_atn && cmd.data[7:5] == `GPD_GRP_LISTEN && cmd.data[4:0] == prim_addr;
   assign my_talk = cmd_atn && cmd.data[7:5] == `GPD_GRP_TALK && cmd.data[4:0] == prim_addr;

   // ----------------------------------------
   // Interface state
   // ----------------------------------------
   logic [4:0] next_prim_addr;
   logic next_addr_reject;
   gpd_rl_t rl, next_rl;
   logic lad, tad, llo, spoll;
   logic next_lad, next_tad, next_llo, next_spoll;
   logic next_trig, next_clr;
   always_comb begin
      next_prim_addr = prim_addr;
      next_addr_reject = 1'b0;
      next_rl = rl;
      next_lad = lad;
      next_tad = tad;
      next_llo = llo;
      next_spoll = spoll;
      next_trig = 1'b0;
      next_clr = 1'b0;
      if (addr_set_stb) begin
         if (addr_set <= `GPD_ADDR_MAX) begin
            next_prim_addr = addr_set;
         end else begin
            next_addr_reject = 1'b1;
         end
      end
      if (cmd_atn) begin
         case (cmd.data)
            `GPD_CMD_UNL: next_lad = 1'b0;
            `GPD_CMD_UNT: next_tad = 1'b0;
            // lockout also disables the local key.
            `GPD_CMD_LLO: next_llo = 1'b1;
            // device clear for every device. pulse flushes queues only.
            `GPD_CMD_DCL: next_clr = 1'b1;
            `GPD_CMD_SPE: next_spoll = 1'b1;
            `GPD_CMD_SPD: next_spoll = 1'b0;
            `GPD_CMD_GTL: if (lad) next_rl = GPD_LOCAL;
            // selective clear only while addressed to listen.
            `GPD_CMD_SDC: if (lad) next_clr = 1'b1;
            // trigger only with bus trigger as source.
            `GPD_CMD_GET: if (lad && trig_src_bus) next_trig = 1'b1;
            default: ;
         endcase
         if (my_listen) begin
            // own listen address idles the talker.
            next_lad = 1'b1;
            next_tad = 1'b0;
            // remote only when addressed to listen with remote enable.
            if (ren_s && rl == GPD_LOCAL) next_rl = GPD_REMOTE;
         end else if (my_talk) begin
            // talker addressing independent of remote state.
            next_tad = 1'b1;
            next_lad = 1'b0;
         end else if (cmd.data[7:5] == `GPD_GRP_TALK) begin
            next_tad = 1'b0;
         end
      end
      // local key returns to local unless locked out.
      if (local_key && rl == GPD_REMOTE && !llo) next_rl = GPD_LOCAL;
      if (!ren_s) begin
         next_rl = GPD_LOCAL;
         next_llo = 1'b0;
      end
      // clear forces local and idle. indicators follow. no settings touched.
      if (ifc_evt) begin
         next_rl = GPD_LOCAL;
         next_lad = 1'b0;
         next_tad = 1'b0;
         next_spoll = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // primary address starts at its default.
         prim_addr <= `GPD_ADDR_RESET;
         addr_reject <= 1'b0;
         rl <= GPD_LOCAL;
         lad <= 1'b0;
         tad <= 1'b0;
         llo <= 1'b0;
         spoll <= 1'b0;
         trig_evt <= 1'b0;
         dev_clear <= 1'b0;
      end else begin
         prim_addr <= next_prim_addr;
         addr_reject <= next_addr_reject;
         rl <= next_rl;
         lad <= next_lad;
         tad <= next_tad;
         llo <= next_llo;
         spoll <= next_spoll;
         trig_evt <= next_trig;
         dev_clear <= next_clr;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic [7:0] next_dio_out;
   // status byte driven while polled and addressed to talk.
   always_comb begin
      next_dio_out = (spoll && tad) ? status_byte : 8'h00;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dio_out <= 8'h00;
      end else begin
         dio_out <= next_dio_out;
      end
   end
   // The answer is released as soon as attention is seen, so a command byte is never corrupted.
   assign dio_oe = tad && !atn_s;
   // remote indicator tracks the remote state.
   assign remote_indicator = (rl == GPD_REMOTE);
   assign talk_indicator = tad;
   assign listen_indicator = lad;
   assign lockout = llo;
   // panel keys masked in remote; the local key is a separate input.
   assign panel_keys_ok = (rl == GPD_REMOTE) ? 8'h00 : panel_keys;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_ADDR_RESET: assert property (@(posedge clk) $fell(sys_rst) |-> prim_addr == `GPD_ADDR_RESET)
      else $error("address not 16 after reset");
   AST_ADDR_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
      addr_set_stb && addr_set > `GPD_ADDR_MAX |=> prim_addr == $past(prim_addr) && addr_reject)
      else $error("bad address accepted");
   AST_REM_NEEDS_LISTEN: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(remote_indicator) |-> $past(my_listen) && $past(ren_s))
      else $error("remote without listen address");
   AST_TALK_ANY: assert property (@(posedge clk) disable iff (sys_rst)
      my_talk && !ifc_evt |=> talk_indicator)
      else $error("talk address missed");
   AST_PANEL_MASK: assert property (@(posedge clk) disable iff (sys_rst)
      remote_indicator |-> panel_keys_ok == 8'h00)
      else $error("panel key passed in remote");
   AST_LOCAL_KEY: assert property (@(posedge clk) disable iff (sys_rst)
      local_key && remote_indicator && !lockout && !my_listen |=> !remote_indicator)
      else $error("local key ignored");
   AST_IFC_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
      ifc_evt |=> !remote_indicator && !talk_indicator && !listen_indicator)
      else $error("clear did not idle");
   AST_LLO_KEY: assert property (@(posedge clk) disable iff (sys_rst)
      lockout && remote_indicator && ren_s && !cmd_atn && !ifc_evt |=> remote_indicator)
      else $error("local key worked under lockout");
   AST_SDC_GATE: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_atn && cmd.data == `GPD_CMD_SDC && !lad |=> !dev_clear)
      else $error("unaddressed selective clear");
   // Command effects land one cycle after the byte is taken.
   AST_DCL_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_atn && cmd.data == `GPD_CMD_DCL |=> dev_clear)
      else $error("device clear not pulsed");
   AST_UNT_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_atn && cmd.data == `GPD_CMD_UNT |=> !talk_indicator)
      else $error("untalk left talker active");
   AST_GTL_LOCAL: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_atn && cmd.data == `GPD_CMD_GTL && lad |=> !remote_indicator)
      else $error("go to local ignored");
   AST_POLL_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
      spoll && tad |=> dio_out == $past(status_byte))
      else $error("status byte not presented");
   AST_GET_SRC: assert property (@(posedge clk) disable iff (sys_rst)
      trig_evt |-> $past(trig_src_bus) && $past(lad))
      else $error("trigger without bus source");
   COV_REMOTE: cover property (@(posedge clk) $rose(remote_indicator));
   COV_LOCKOUT: cover property (@(posedge clk) lockout && local_key && remote_indicator);
   COV_IFC: cover property (@(posedge clk) ifc_evt && talk_indicator);
   COV_POLL: cover property (@(posedge clk) dio_oe && spoll);
endmodule
`default_nettype wire

// file: dv/gpd_ctl_model.sv
// Behavioural bus controller that drives the command side of the instrument bus.
`timescale 1ns/1ps
`default_nettype none
module gpd_ctl_model (
   // Clock
   input wire logic clk,
   // Controller lines, active high
   output logic ren,
   output logic ifc,
   output logic atn,
   output logic dav,
   output logic [7:0] dio
);
   // Extra cycles of valid data, so that the bench can make the controller slow.
   int slow = 0;

   // All lines start released.
   initial begin
      ren = 1'b0;
      ifc = 1'b0;
      atn = 1'b0;
      dav = 1'b0;
      dio = 8'h00;
   end

   // unique address
   // Only the block under test is on the bus, so no other party can share its address.
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      #1 atn = 1'b1;
      dio = b;
      repeat (3) @(posedge clk);
      #1 dav = 1'b1;
      repeat (6 + slow) @(posedge clk);
      // Released data lines fall back to the low, false level.
      #1 dav = 1'b0;
      dio = 8'h00;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // Sets remote enable and attention, then lets the synchronisers settle.
   task automatic drive(input logic r, input logic a);
      @(posedge clk);
      #1 ren = r;
      atn = a;
      repeat (5) @(posedge clk);
      #1;
   endtask

   // interface clear width
   // The caller passes the hold in cycles; it must reach the minimum width to count.
   task automatic clear_bus(input int n);
      @(posedge clk);
      #1 ifc = 1'b1;
      repeat (n) @(posedge clk);
      #1 ifc = 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// file: dv/gpd_device_tb.sv
// Self-checking bench for the device-side instrument bus interface.
`include "gpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gpd_device_tb;
   import gpd_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ren_pin, ifc_pin, atn_pin, dav_pin, dio_oe;
   logic [7:0] m_dio, dio_pin, dio_out, panel_keys, panel_keys_ok, status_byte;
   logic [4:0] addr_set, prim_addr, my, oth;
   logic addr_set_stb, addr_reject, local_key, trig_src_bus, trig_evt, dev_clear;
   logic remote_indicator, talk_indicator, listen_indicator, lockout;
   int fails = 0, n_checks = 0, n_clr = 0, n_trg = 0, n_rej = 0, cyc = 0, seed = 59, c0;

   // Wired data bus: the device answer is ORed onto the controller lines.
   assign dio_pin = m_dio | (dio_oe ? dio_out : 8'h00);

   initial forever #12.5 clk = ~clk;

   gpd_ctl_model u_gpd_ctl_model (.clk, .ren(ren_pin), .ifc(ifc_pin), .atn(atn_pin), .dav(dav_pin), .dio(m_dio));
   gpd_device u_gpd_device (.clk, .sys_rst, .ren_pin, .ifc_pin, .atn_pin, .dav_pin, .dio_pin, .addr_set,
      .addr_set_stb, .addr_reject, .local_key, .panel_keys, .panel_keys_ok, .status_byte, .trig_src_bus,
      .trig_evt, .dev_clear, .prim_addr, .dio_out, .dio_oe, .remote_indicator, .talk_indicator,
      .listen_indicator, .lockout);

   // Count one-cycle pulses; the cycle ceiling cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (dev_clear === 1'b1) n_clr++;
      if (trig_evt === 1'b1) n_trg++;
      if (addr_reject === 1'b1) n_rej++;
      if (cyc == 12000) begin
         fails++;
         results();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] b);
      u_gpd_ctl_model.send(b);
   endtask

   task automatic press();
      @(posedge clk);
      #1 local_key = 1'b1;
      @(posedge clk);
      #1 local_key = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // Expected primary address after a setting: out-of-range values leave it as it was.
   function automatic logic [4:0] exp_addr(input logic [4:0] cur, input logic [4:0] v);
      return (v <= 5'd30) ? v : cur;
   endfunction

   // Expected address follows only accepted settings.
   task automatic set_addr(input logic [4:0] v);
      c0 = n_rej;
      @(posedge clk);
      #1 addr_set = v;
      addr_set_stb = 1'b1;
      @(posedge clk);
      #1 addr_set_stb = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(8'(n_rej - c0), 8'(v > 5'd30));
      my = exp_addr(my, v);
      chk(8'(prim_addr), 8'(my));
   endtask

   task automatic results();
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      {addr_set_stb, local_key, trig_src_bus} = 3'b000;
      addr_set = 5'h00;
      panel_keys = 8'h00;
      status_byte = 8'h00;
      repeat (12) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      #1 my = 5'h10;
      chk(8'(prim_addr), 8'h10);
      chk(8'({remote_indicator, talk_indicator, listen_indicator}), 8'h00);
      for (int i = 0; i < 6; i++) set_addr(i == 0 ? 5'd31 : i == 1 ? 5'd30 : 5'($random(seed)));
      oth = (my == 5'd30) ? 5'd0 : my + 5'd1;
      u_gpd_ctl_model.drive(1'b1, 1'b1);
      chk(8'(remote_indicator), 8'h00);
      cmd({`GPD_GRP_LISTEN, oth});
      chk(8'({remote_indicator, listen_indicator}), 8'h00);
      cmd({`GPD_GRP_LISTEN, my});
      chk(8'({remote_indicator, listen_indicator}), 8'h03);
      panel_keys = 8'($random(seed));
      #1 chk(panel_keys_ok, 8'h00);
      // local key, lockout, go to local
      press();
      chk(8'(remote_indicator), 8'h00);
      chk(panel_keys_ok, panel_keys);
      cmd({`GPD_GRP_LISTEN, my});
      cmd(`GPD_CMD_LLO);
      chk(8'(lockout), 8'h01);
      press();
      chk(8'(remote_indicator), 8'h01);
      chk(panel_keys_ok, 8'h00);
      u_gpd_ctl_model.slow = 20;
      cmd(`GPD_CMD_GTL);
      u_gpd_ctl_model.slow = 0;
      chk(8'(remote_indicator), 8'h00);
      chk(panel_keys_ok, panel_keys);
      cmd({`GPD_GRP_TALK, my});
      chk(8'({remote_indicator, talk_indicator}), 8'h01);
      cmd({`GPD_GRP_LISTEN, my});
      chk(8'(talk_indicator), 8'h00);
      cmd({`GPD_GRP_TALK, my});
      cmd(`GPD_CMD_UNT);
      chk(8'(talk_indicator), 8'h00);
      status_byte = 8'($random(seed));
      cmd({`GPD_GRP_TALK, my});
      cmd(`GPD_CMD_SPE);
      u_gpd_ctl_model.drive(1'b1, 1'b0);
      chk(8'(dio_oe), 8'h01);
      chk(dio_out, status_byte);
      cmd(`GPD_CMD_SPD);
      u_gpd_ctl_model.drive(1'b1, 1'b0);
      chk(dio_out, 8'h00);
      c0 = n_clr;
      cmd(`GPD_CMD_DCL);
      cmd(`GPD_CMD_UNL);
      cmd(`GPD_CMD_SDC);
      chk(8'(n_clr - c0), 8'h01);
      cmd({`GPD_GRP_LISTEN, my});
      cmd(`GPD_CMD_SDC);
      chk(8'(n_clr - c0), 8'h02);
      c0 = n_trg;
      cmd(`GPD_CMD_GET);
      trig_src_bus = 1'b1;
      cmd(`GPD_CMD_GET);
      chk(8'(n_trg - c0), 8'h01);
      cmd({`GPD_GRP_TALK, my});
      chk(8'({remote_indicator, talk_indicator}), 8'h03);
      u_gpd_ctl_model.clear_bus(4010);
      chk(8'({remote_indicator, talk_indicator, listen_indicator}), 8'h00);
      chk(8'(prim_addr), 8'(my));
      // listener cleared only by a full-width clear
      cmd({`GPD_GRP_LISTEN, my});
      chk(8'({remote_indicator, listen_indicator}), 8'h03);
      u_gpd_ctl_model.clear_bus(40);
      chk(8'({remote_indicator, listen_indicator}), 8'h03);
      u_gpd_ctl_model.clear_bus(4010);
      chk(8'({remote_indicator, listen_indicator}), 8'h00);
      results();
   end
endmodule
`default_nettype wire
